// ==== shared/asrp_pkg.sv ====
`default_nettype none
package asrp_pkg;
  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_W = 24;
  localparam int RES_W = FRAME_W - 1;
  localparam int CNT_W = 5;
  localparam int FIFO_DEPTH = 4;
  localparam logic [CNT_W-1:0] FRAME_CNT = CNT_W'(FRAME_W);
  localparam logic [CNT_W-1:0] LAST_IDX = CNT_W'(FRAME_W - 1);
  localparam logic FLAG_BUSY = 1'b1;
  localparam logic FLAG_READY = 1'b0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  localparam int POR_TIME_MS = 1;
  localparam int CONV60_TIME_MS = 133;
  localparam int CONV50_TIME_MS = 160;
  localparam int POR_CYC = POR_TIME_MS * CYC_PER_MS;
  localparam int CONV60_CYC = CONV60_TIME_MS * CYC_PER_MS;
  localparam int CONV50_CYC = CONV50_TIME_MS * CYC_PER_MS;
  localparam int SCK_PERIOD_NS = 64;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SETTLE_CYC = 12;
  localparam int GAP_CYC = 4;
  localparam int WAIT_W = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [RES_W-1:0] asrp_result_type;
  typedef logic [FRAME_W-1:0] asrp_frame_type;
  typedef enum logic [1:0] {D_POR, D_CONV, D_SLEEP, D_OUT} asrp_dev_state_type;
  typedef enum logic [2:0] {H_IDLE, H_SEL, H_WAIT, H_CLK, H_DONE} asrp_host_state_type;
endpackage : asrp_pkg
`default_nettype wire

// ==== shared/asrp_link_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface asrp_link_if;
  logic shift_clk;
  logic sel_n;
  logic result_drive;
  logic result_oe_n;
  logic serial_result_out;

  // Released line reads high through the board pull-up
  assign serial_result_out = result_oe_n ? 1'b1 : result_drive;

  modport dev (input shift_clk, input sel_n, output result_drive, output result_oe_n);
  modport host (output shift_clk, output sel_n, input serial_result_out);
endinterface : asrp_link_if
`default_nettype wire

// ==== logic/asrp_device.sv ====
// How it works
// - Result leaves serially, most significant bit first
// - Deselected means output driver released
// - Selected while converting shows busy flag, asleep shows ready flag
// - Select rising mid-frame aborts, starts new conversion
// - Select held low converts back to back
// - Select falling edge picks clock mode; host holds clock low
// - Conversion done while deselected enters sleep
// - Result held until first clock rise while selected
// - Output changes on falling edge; host samples rising
// - Host takes flag first rise, last bit 24th
// - 24th falling edge starts conversion, output high
// - After frame host may watch flag or deselect
// - Four clocking configurations exist, external ones built here
// - Clock mode latched at power-on end
// - Two-wire select low shows flag during convert, sleep
// - Finished result loads at falling flag edge
// - Clock high picks internal mode, low picks external
`timescale 1ns/1ns
`default_nettype none
module asrp_device #(
  parameter int POR_CYC_P = asrp_pkg::POR_CYC,
  parameter int CONV60_CYC_P = asrp_pkg::CONV60_CYC,
  parameter int CONV50_CYC_P = asrp_pkg::CONV50_CYC
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  asrp_link_if.dev link,
  input wire logic rejection_select_pin,
  input wire asrp_pkg::asrp_result_type conv_result,
  output logic ext_mode,
  output logic converting,
  output logic conv_done
);
  import asrp_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  asrp_dev_state_type state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  asrp_frame_type frame_r, frame_nxt;
  logic hold_r, hold_nxt;
  logic ext_mode_r, ext_mode_nxt;
  logic done_pulse_r, done_pulse_nxt;
  logic drive_r, drive_nxt;
  logic oe_n_r, oe_n_nxt;
  logic sel_s1_r, sel_s2_r, sel_p_r;
  logic clk_s1_r, clk_s2_r;
  logic rej_s1_r, rej_s2_r;
  logic bit_s1_r, bit_s2_r;
  logic start_s1_r, start_s2_r;
  logic fin_s1_r, fin_s2_r;
  logic sel_fall, sel_rise;
  logic [31:0] conv_limit;
  logic link_rst_n;
  logic started_r;
  logic [CNT_W-1:0] fall_cnt_r, fall_cnt_nxt;
  logic [CNT_W-1:0] idx;
  logic bit_r, bit_nxt;
  logic fin_r, fin_nxt;

  // ****************************************
  // Synchronisers into sys_clk
  // ****************************************
  // Pins and link-domain levels, two flops each
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      sel_p_r <= 1'b1;
      clk_s1_r <= 1'b1;
      clk_s2_r <= 1'b1;
      rej_s1_r <= 1'b0;
      rej_s2_r <= 1'b0;
      bit_s1_r <= 1'b0;
      bit_s2_r <= 1'b0;
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      fin_s1_r <= 1'b0;
      fin_s2_r <= 1'b0;
    end
    else
    begin
      sel_s1_r <= link.sel_n;
      sel_s2_r <= sel_s1_r;
      sel_p_r <= sel_s2_r;
      clk_s1_r <= link.shift_clk;
      clk_s2_r <= clk_s1_r;
      rej_s1_r <= rejection_select_pin;
      rej_s2_r <= rej_s1_r;
      bit_s1_r <= bit_r;
      bit_s2_r <= bit_s1_r;
      start_s1_r <= started_r;
      start_s2_r <= start_s1_r;
      fin_s1_r <= fin_r;
      fin_s2_r <= fin_s1_r;
    end
  end

  assign sel_fall = sel_p_r & ~sel_s2_r;
  assign sel_rise = ~sel_p_r & sel_s2_r;
  // Pin high picks the longer 50 Hz conversion
  assign conv_limit = rej_s2_r ? 32'(CONV50_CYC_P - 1) : 32'(CONV60_CYC_P - 1);

  // ****************************************
  // Conversion cycle control
  // ****************************************
  // Next state of the conversion sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    frame_nxt = frame_r;
    ext_mode_nxt = ext_mode_r;
    done_pulse_nxt = 1'b0;
    // Mode follows the clock level at each select fall after power-on
    if (sel_fall && state_r != D_POR)
    begin
      ext_mode_nxt = ~clk_s2_r;
    end
    case (state_r)
      D_POR:
      begin
        cnt_nxt = cnt_r + 32'h0000_0001;
        if (cnt_r == 32'(POR_CYC_P - 1))
        begin
          ext_mode_nxt = ~clk_s2_r;
          cnt_nxt = '0;
          state_nxt = D_CONV;
        end
      end
      D_CONV:
      begin
        cnt_nxt = cnt_r + 32'h0000_0001;
        if (cnt_r == conv_limit)
        begin
          // Static register loads as the flag falls
          frame_nxt = {FLAG_READY, conv_result};
          done_pulse_nxt = 1'b1;
          cnt_nxt = '0;
          state_nxt = D_SLEEP;
        end
      end
      D_SLEEP:
      begin
        // Result waits here until the first rise while selected
        if (start_s2_r && !sel_s2_r && ext_mode_r)
        begin
          state_nxt = D_OUT;
        end
        // A first rise seen late still counts when select rises first
        else if (start_s2_r && sel_rise && ext_mode_r)
        begin
          state_nxt = D_CONV;
        end
      end
      D_OUT:
      begin
        if (fin_s2_r)
        begin
          state_nxt = D_CONV;
        end
        else if (sel_rise)
        begin
          state_nxt = D_CONV;
        end
      end
      default:
      begin
        state_nxt = D_POR;
      end
    endcase
    // Link logic is held cleared while no result is on offer
    hold_nxt = (state_nxt == D_CONV) || (state_nxt == D_POR);
    // Busy flag high, ready flag low, data bits during output
    if (state_nxt == D_OUT)
    begin
      drive_nxt = bit_s2_r;
    end
    else if (state_nxt == D_SLEEP)
    begin
      drive_nxt = FLAG_READY;
    end
    else
    begin
      drive_nxt = FLAG_BUSY;
    end
    oe_n_nxt = sel_s2_r;
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= D_POR;
      cnt_r <= '0;
      frame_r <= '0;
      hold_r <= 1'b1;
      ext_mode_r <= 1'b0;
      done_pulse_r <= 1'b0;
      drive_r <= FLAG_BUSY;
      oe_n_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      frame_r <= frame_nxt;
      hold_r <= hold_nxt;
      ext_mode_r <= ext_mode_nxt;
      done_pulse_r <= done_pulse_nxt;
      drive_r <= drive_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign link.result_drive = drive_r;
  assign link.result_oe_n = oe_n_r;
  assign ext_mode = ext_mode_r;
  assign converting = hold_r;
  assign conv_done = done_pulse_r;

  // ****************************************
  // Link clock domain
  // ****************************************
  // Frame logic is cleared by deselect or a pending conversion,
  // since the shift clock stands still between frames
  assign link_rst_n = rst_n & ~link.sel_n & ~hold_r;

  // First rise with select low opens the data output state
  always_ff @(posedge link.shift_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      started_r <= 1'b0;
    end
    else
    begin
      started_r <= 1'b1;
    end
  end

  // Next bit on each falling edge; frame_r is static during a frame
  always_comb
  begin
    fall_cnt_nxt = fall_cnt_r;
    bit_nxt = bit_r;
    fin_nxt = fin_r;
    idx = LAST_IDX - fall_cnt_r - 1'b1;
    if (fall_cnt_r != FRAME_CNT)
    begin
      fall_cnt_nxt = fall_cnt_r + 1'b1;
      if (fall_cnt_nxt == FRAME_CNT)
      begin
        bit_nxt = FLAG_BUSY;
        fin_nxt = 1'b1;
      end
      else
      begin
        bit_nxt = frame_r[idx];
      end
    end
  end

  // Falling-edge registers of the frame
  always_ff @(negedge link.shift_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      fall_cnt_r <= '0;
      bit_r <= FLAG_READY;
      fin_r <= 1'b0;
    end
    else
    begin
      fall_cnt_r <= fall_cnt_nxt;
      bit_r <= bit_nxt;
      fin_r <= fin_nxt;
    end
  end
endmodule : asrp_device
`default_nettype wire

// ==== logic/asrp_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Result buffer
// ****************************************
module asrp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and fill count update
  always_comb
  begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (push)
    begin
      wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
    end
    if (pop)
    begin
      rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
    end
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule : asrp_fifo

// ****************************************
// Reading end
// ****************************************
module asrp_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  asrp_link_if.host link,
  input wire logic run,
  input wire logic two_wire,
  input wire logic abort_req,
  output logic [asrp_pkg::RES_W-1:0] res_data,
  output logic res_valid,
  input wire logic res_ready,
  output logic busy
);
  import asrp_pkg::*;

  asrp_host_state_type state_r, state_nxt;
  logic [WAIT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] bits_r, bits_nxt;
  asrp_result_type shift_r, shift_nxt;
  logic sck_r, sck_nxt;
  logic sel_n_r, sel_n_nxt;
  logic push_r, push_nxt;
  logic busy_r;
  logic in_s1_r, in_s2_r;
  logic fifo_ready;

  // Serial line is asynchronous here, two flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_s1_r <= 1'b1;
      in_s2_r <= 1'b1;
    end
    else
    begin
      in_s1_r <= link.serial_result_out;
      in_s2_r <= in_s1_r;
    end
  end

  // Frame sequencer; clock low whenever select falls, dropped on the same edge select rises on abort
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 1'b1;
    bits_nxt = bits_r;
    shift_nxt = shift_r;
    sck_nxt = 1'b0;
    sel_n_nxt = sel_n_r;
    push_nxt = 1'b0;
    case (state_r)
      H_IDLE:
      begin
        sel_n_nxt = 1'b1;
        if (cnt_r >= WAIT_W'(GAP_CYC))
        begin
          cnt_nxt = cnt_r;
          if (run && fifo_ready)
          begin
            sel_n_nxt = 1'b0;
            cnt_nxt = '0;
            state_nxt = H_SEL;
          end
        end
      end
      H_SEL:
      begin
        if (cnt_r == WAIT_W'(SETTLE_CYC))
        begin
          state_nxt = H_WAIT;
        end
      end
      H_WAIT:
      begin
        if (abort_req || !run)
        begin
          sel_n_nxt = 1'b1;
          cnt_nxt = '0;
          state_nxt = H_IDLE;
        end
        else if (in_s2_r == FLAG_READY && fifo_ready)
        begin
          cnt_nxt = '0;
          bits_nxt = '0;
          state_nxt = H_CLK;
        end
      end
      H_CLK:
      begin
        sck_nxt = sck_r;
        if (abort_req)
        begin
          sck_nxt = 1'b0;
          sel_n_nxt = 1'b1;
          cnt_nxt = '0;
          state_nxt = H_IDLE;
        end
        else if (cnt_r == WAIT_W'(SCK_HALF_CYC - 1))
        begin
          cnt_nxt = '0;
          sck_nxt = ~sck_r;
          if (!sck_r)
          begin
            // Sample on the rise; first rise carries the flag
            bits_nxt = bits_r + 1'b1;
            if (bits_r != '0)
            begin
              shift_nxt = {shift_r[RES_W-2:0], in_s2_r};
            end
          end
          else if (bits_r == FRAME_CNT)
          begin
            state_nxt = H_DONE;
          end
        end
      end
      H_DONE:
      begin
        push_nxt = 1'b1;
        cnt_nxt = '0;
        // Two-wire keeps select low and watches the flag again
        sel_n_nxt = ~two_wire;
        state_nxt = two_wire ? H_SEL : H_IDLE;
      end
      default:
      begin
        sel_n_nxt = 1'b1;
        state_nxt = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= H_IDLE;
      cnt_r <= '0;
      bits_r <= '0;
      shift_r <= '0;
      sck_r <= 1'b0;
      sel_n_r <= 1'b1;
      push_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      shift_r <= shift_nxt;
      sck_r <= sck_nxt;
      sel_n_r <= sel_n_nxt;
      push_r <= push_nxt;
      busy_r <= state_nxt != H_IDLE;
    end
  end

  assign link.shift_clk = sck_r;
  assign link.sel_n = sel_n_r;
  assign busy = busy_r;

  // Frames start only with room, so a push is never lost
  asrp_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push_r),
    .in_ready(fifo_ready),
    .in_data(shift_r),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );
endmodule : asrp_host
`default_nettype wire

// ==== bench/asrp_link_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Link rules seen on the wires
// ****
module asrp_link_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic sel_n,
  input wire logic result_drive,
  input wire logic result_oe_n,
  input wire logic serial_result_out
);
  logic sck_r;
  logic [4:0] rise_r;
  logic [4:0] rise_nxt;
  logic [7:0] since_r;
  logic [7:0] since_nxt;

  // Frame position; a deselect always ends the frame
  always_comb
  begin
    rise_nxt = rise_r;
    since_nxt = (since_r == 8'hff) ? since_r : since_r + 8'h01;
    if (sck_r && !shift_clk)
    begin
      since_nxt = 8'h00;
      rise_nxt = (rise_r == 5'h18) ? 5'h00 : rise_r;
    end
    if (!sck_r && shift_clk)
      rise_nxt = rise_r + 5'h01;
    if (sel_n)
      rise_nxt = 5'h00;
  end

  // Saturating age of the last clock fall
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_r <= 1'b0;
      rise_r <= 5'h00;
      since_r <= 8'hff;
    end
    else
    begin
      sck_r <= shift_clk;
      rise_r <= rise_nxt;
      since_r <= since_nxt;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Fall that closes a full frame
  sequence s_last_fall;
    sck_r && !shift_clk && !sel_n && rise_r == 5'h18;
  endsequence
  sequence s_busy_hold;
    serial_result_out [*4];
  endsequence

  a_desel_release: assert property (sel_n [*6] |-> result_oe_n)
    else $error("driver not released");
  a_select_drive: assert property ((!sel_n) [*6] |-> !result_oe_n)
    else $error("selected but not driving");
  a_enable_cause: assert property ($fell(result_oe_n) |-> !sel_n && !$past(sel_n))
    else $error("driving without select");
  a_clock_low_select: assert property ($fell(sel_n) |-> !shift_clk)
    else $error("select fell with clock high");
  a_flag_first: assert property (shift_clk && !sck_r && !sel_n && rise_r == 5'h00
    |-> !serial_result_out)
    else $error("first bit not ready flag");
  a_high_clk_stable: assert property ((!sel_n && shift_clk) [*6] |-> $stable(result_drive))
    else $error("data moved while clock high");
  a_change_after_fall: assert property (!sel_n && rise_r >= 5'h01 && rise_r <= 5'h17
    && $changed(result_drive) |-> since_r <= 8'h06)
    else $error("data moved away from a fall");
  a_frame_end_busy: assert property (s_last_fall |-> ##[1:6] serial_result_out
    ##1 s_busy_hold)
    else $error("no busy flag after last fall");
  a_result_held: assert property (!sel_n && !shift_clk && rise_r == 5'h00 && since_r > 8'h08
    && !serial_result_out ##1 !sel_n && !shift_clk |-> !serial_result_out)
    else $error("ready flag lost before clocking");
endmodule : asrp_link_properties
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Both ends joined, results checked
// ****
module testbench;
  import asrp_pkg::*;
  localparam int CONV_LO = 200;
  localparam int CONV_HI = 320;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rejection_select_pin = 1'b0;
  asrp_result_type conv_result = 23'h000000;
  logic run = 1'b0;
  logic two_wire = 1'b0;
  logic abort_req = 1'b0;
  logic res_ready = 1'b0;
  logic stall = 1'b0;
  logic sck_q;
  logic ext_mode;
  logic converting;
  logic conv_done;
  logic [RES_W-1:0] res_data;
  logic res_valid;
  logic busy;
  int err_total = 0;
  int check_count = 0;
  int pops = 0;
  int nres = 0;
  int conv_len = 0;
  int last_len = 0;
  int n;
  int k;
  int m;
  int p0;
  int q0;
  asrp_result_type exp_q[$];
  asrp_result_type corner[4] = '{23'h000000, 23'h7fffff, 23'h555555, 23'h2aaaaa};

  always #2 sys_clk = ~sys_clk;

  asrp_link_if asrp_link_if_inst ();
  asrp_device #(.POR_CYC_P(20), .CONV60_CYC_P(CONV_LO), .CONV50_CYC_P(CONV_HI))
    asrp_device_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(asrp_link_if_inst),
    .rejection_select_pin(rejection_select_pin), .conv_result(conv_result),
    .ext_mode(ext_mode), .converting(converting), .conv_done(conv_done));
  asrp_host asrp_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(asrp_link_if_inst),
    .run(run), .two_wire(two_wire), .abort_req(abort_req), .res_data(res_data),
    .res_valid(res_valid), .res_ready(res_ready), .busy(busy));
  asrp_link_properties asrp_link_properties_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .shift_clk(asrp_link_if_inst.shift_clk), .sel_n(asrp_link_if_inst.sel_n),
    .result_drive(asrp_link_if_inst.result_drive),
    .result_oe_n(asrp_link_if_inst.result_oe_n),
    .serial_result_out(asrp_link_if_inst.serial_result_out));

  // Results captured as loaded, words compared as popped
  always @(posedge sys_clk)
  begin
    res_ready <= #1 !stall && ($urandom_range(3) != 0);
    if (conv_done === 1'b1)
    begin
      exp_q.push_back(conv_result);
      nres++;
      conv_result <= #1 (nres < 4) ? corner[nres] : asrp_result_type'($urandom);
    end
    if (res_valid === 1'b1 && res_ready === 1'b1)
    begin
      pops++;
      check(exp_q.size() > 0 && res_data === exp_q.pop_front(), "result word");
    end
    conv_len = (converting === 1'b1) ? conv_len + 1 : 0;
    if (converting === 1'b1)
      last_len = conv_len;
  end

  function automatic int exp_len(input int sel);
    return sel ? CONV_HI : CONV_LO;
  endfunction : exp_len

  task automatic check(input bit ok, input string msg);
    check_count++;
    if (!ok)
    begin
      err_total++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic hang(input string msg);
    check(1'b0, msg);
    print_verdict();
  endtask : hang

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : tick

  // Quiet link: host idle, buffer empty, converter asleep for 8 cycles
  task automatic settle();
    run = 1'b0;
    two_wire = 1'b0;
    stall = 1'b0;
    k = 0;
    for (n = 0; n < 5000 && k < 8; n++)
    begin
      tick(1);
      k = (busy === 1'b0 && res_valid === 1'b0 && converting === 1'b0) ? k + 1 : 0;
    end
    if (k < 8)
      hang("settle");
  endtask : settle

  initial
  begin
    void'($urandom(48));
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    settle();
    // Clock held low through power-on, so external clocking is latched
    check(ext_mode === 1'b1, "clock mode");
    check(asrp_link_if_inst.result_oe_n === 1'b1, "driver released");
    check(exp_q.size() == 1, "result held asleep");
    $display("test power-on done");
    // Single frames while the consumer stalls at random
    rejection_select_pin = 1'($urandom_range(1));
    run = 1'b1;
    p0 = pops + 6;
    for (n = 0; n < 20000 && pops < p0; n++)
      tick(1);
    if (pops < p0)
      hang("stream");
    settle();
    check(exp_q.size() == 1, "one pending result");
    $display("test stream done");
    // Buffer fills, then frames are refused and the converter sleeps
    stall = 1'b1;
    run = 1'b1;
    for (n = 0; n < 20000 && !(exp_q.size() == 5 && converting === 1'b0); n++)
      tick(1);
    tick(50);
    check(exp_q.size() == 5 && converting === 1'b0, "refused while full");
    check(asrp_link_if_inst.result_oe_n === 1'b1, "released while asleep");
    p0 = pops;
    settle();
    check(pops - p0 == FIFO_DEPTH, "buffer depth");
    $display("test buffer done");
    // Select held low converts continuously at the chosen rate
    for (m = 0; m < 2; m++)
    begin
      two_wire = 1'b1;
      run = 1'b1;
      rejection_select_pin = m[0];
      p0 = nres + 2;
      for (n = 0; n < 20000 && nres < p0; n++)
        tick(1);
      if (nres < p0)
        hang("two-wire");
      tick(2);
      check(last_len >= exp_len(m) - 4 && last_len <= exp_len(m) + 8, "rate");
      check(asrp_link_if_inst.sel_n === 1'b0, "select held low");
    end
    settle();
    $display("test two-wire done");
    // Select raised at the first, 23rd and a random clock of a frame
    for (m = 0; m < 3; m++)
    begin
      p0 = (m == 0) ? 1 : (m == 1) ? 23 : 2 + $urandom_range(20);
      q0 = pops;
      run = 1'b1;
      sck_q = 1'b0;
      k = 0;
      for (n = 0; n < 5000 && k < p0; n++)
      begin
        tick(1);
        k += (asrp_link_if_inst.shift_clk === 1'b1 && sck_q === 1'b0) ? 1 : 0;
        sck_q = asrp_link_if_inst.shift_clk;
      end
      if (k < p0)
        hang("abort");
      abort_req = 1'b1;
      run = 1'b0;
      tick(1);
      abort_req = 1'b0;
      exp_q.delete();
      for (n = 0; n < 40 && converting !== 1'b1; n++)
        tick(1);
      check(converting === 1'b1, "abort restarts");
      settle();
      check(exp_q.size() == 1 && pops == q0, "aborted word dropped");
    end
    $display("test abort done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
